// ==== src/tcm_consts.svh ====
`ifndef TCM_CONSTS_SVH
`define TCM_CONSTS_SVH
`define TCM_ADDR_MODE 8'h89
`define TCM_ADDR_CTRL 8'h88
`define TCM_ADDR_LO0 8'h8a
`define TCM_ADDR_LO1 8'h8b
`define TCM_ADDR_HI0 8'h8c
`define TCM_ADDR_HI1 8'h8d
`define TCM_MODE_RST 8'h00
`define TCM_CTRL_RST 8'h00
`define TCM_CNT_RST 8'h00
`define TCM_GATE1_BIT 7
`define TCM_CT1_BIT 6
`define TCM_MODE1_HI 5
`define TCM_MODE1_LO 4
`define TCM_GATE0_BIT 3
`define TCM_CT0_BIT 2
`define TCM_MODE0_HI 1
`define TCM_MODE0_LO 0
`define TCM_OVF1_BIT 7
`define TCM_RUN1_BIT 6
`define TCM_OVF0_BIT 5
`define TCM_RUN0_BIT 4
`define TCM_PRESC_MAX 5'h1f
`define TCM_BYTE_MAX 8'hff
`endif

// ==== src/tcm_pkg.sv ====
`default_nettype none
package tcm_pkg;
  typedef enum logic [1:0] {
    TCM_MODE_PRESC = 2'h0,
    TCM_MODE_WIDE = 2'h1,
    TCM_MODE_RELOAD = 2'h2,
    TCM_MODE_SPLIT = 2'h3
  } tcm_mode_t;
endpackage
`default_nettype wire

// ==== src/tcm_edge_detect.sv ====
`default_nettype none
// one-cycle pulse when the pin goes high in one sample and low in the next
module tcm_edge_detect (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic pin,
  output logic fall
);
  logic prev_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else if (ce) begin
      prev_q <= pin;
    end
  end
  assign fall = prev_q & ~pin;
endmodule
`default_nettype wire

// ==== src/tcm_timer01.sv ====
`default_nettype none
`include "tcm_consts.svh"
// Summary of operation
// - each timer is a high and a low byte, forming a 16-bit counter in mode 01
// - timer operation advances the count once per clock
// - counter operation counts a high sample followed by a low sample on the event pin
// - edge detection spans two clocks, so counting is at most half the clock rate
// - mode bit 7 set makes timer 1 need its gate pin high plus run bit
// - mode bit 6 selects timer 1 source: event pin falls or clock
// - timer 1 mode field in bits 5:4; value 11 stops timer 1
// - mode 00: high byte counts, low byte is a 5-bit prescaler
// - mode 01: both bytes cascade as one 16-bit counter
// - mode 10: low byte counts and reloads from high byte on overflow
// - mode bit 3 set makes timer 0 need its gate pin high plus run bit
// - mode register at 89h resets to zero, written as a whole byte
// - mode bit 2 selects timer 0 source: event pin falls or clock
// - timer 0 mode 11: low byte under timer 0 controls, high byte under timer 1 run bit only
// - overflow sets a flag; interrupt vectoring clears it
// - each timer counts only while its run bit is set; timer 0 high byte in mode 11 uses the timer 1 run bit
module tcm_timer01 (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WE,
  output logic [7:0] SFR_RDATA,
  output logic SFR_HIT,
  input wire logic EVENT_PIN_ZERO,
  input wire logic EVENT_PIN_ONE,
  input wire logic GATE_PIN_ZERO,
  input wire logic GATE_PIN_ONE,
  input wire logic VECTOR_ACK_ZERO,
  input wire logic VECTOR_ACK_ONE,
  output logic OVERFLOW_FLAG_ZERO,
  output logic OVERFLOW_FLAG_ONE,
  output tcm_pkg::tcm_mode_t MODE_ZERO,
  output tcm_pkg::tcm_mode_t MODE_ONE
);
  import tcm_pkg::*;

  logic rst_meta_q, rst_sync_q;
  logic [7:0] mode_q, ctrl_q, lo0_q, hi0_q, lo1_q, hi1_q;
  logic [7:0] lo0_d, hi0_d, lo1_d, hi1_d;
  logic [7:0] rdata_q;
  logic fall0, fall1;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  tcm_edge_detect u_edge0 (
    .clk(REF_CLK),
    .rst_n(rst_sync_q),
    .ce(CE),
    .pin(EVENT_PIN_ZERO),
    .fall(fall0)
  );
  tcm_edge_detect u_edge1 (
    .clk(REF_CLK),
    .rst_n(rst_sync_q),
    .ce(CE),
    .pin(EVENT_PIN_ONE),
    .fall(fall1)
  );

  // register decode
  wire wr_mode = SFR_WE & (SFR_ADDR == `TCM_ADDR_MODE);
  wire wr_ctrl = SFR_WE & (SFR_ADDR == `TCM_ADDR_CTRL);
  wire wr_lo0 = SFR_WE & (SFR_ADDR == `TCM_ADDR_LO0);
  wire wr_hi0 = SFR_WE & (SFR_ADDR == `TCM_ADDR_HI0);
  wire wr_lo1 = SFR_WE & (SFR_ADDR == `TCM_ADDR_LO1);
  wire wr_hi1 = SFR_WE & (SFR_ADDR == `TCM_ADDR_HI1);
  wire hit = (SFR_ADDR == `TCM_ADDR_MODE) | (SFR_ADDR == `TCM_ADDR_CTRL) | (SFR_ADDR == `TCM_ADDR_LO0) |
             (SFR_ADDR == `TCM_ADDR_HI0) | (SFR_ADDR == `TCM_ADDR_LO1) | (SFR_ADDR == `TCM_ADDR_HI1);

  wire tcm_mode_t mode0 = tcm_mode_t'(mode_q[`TCM_MODE0_HI:`TCM_MODE0_LO]);
  wire tcm_mode_t mode1 = tcm_mode_t'(mode_q[`TCM_MODE1_HI:`TCM_MODE1_LO]);
  wire run0 = ctrl_q[`TCM_RUN0_BIT];
  wire run1 = ctrl_q[`TCM_RUN1_BIT];

  // gate pin only matters when gating is selected
  wire en0 = run0 & (~mode_q[`TCM_GATE0_BIT] | GATE_PIN_ZERO);
  wire en1 = run1 & (~mode_q[`TCM_GATE1_BIT] | GATE_PIN_ONE);
  wire tick0 = mode_q[`TCM_CT0_BIT] ? fall0 : 1'b1;
  wire tick1 = mode_q[`TCM_CT1_BIT] ? fall1 : 1'b1;
  wire inc0 = CE & en0 & tick0;
  wire split0 = (mode0 == TCM_MODE_SPLIT);
  // in split mode timer 1 shares its run bit with the high byte of timer 0 and keeps counting under it
  wire inc1 = CE & en1 & tick1 & (mode1 != TCM_MODE_SPLIT);
  wire inc0_hi_split = CE & run1;

  logic ovf0, ovf1, ovf1_split;

  // timer 0 next state
  always_comb begin
    lo0_d = lo0_q;
    hi0_d = hi0_q;
    ovf0 = 1'b0;
    ovf1_split = 1'b0;
    if (inc0) begin
      unique case (mode0)
        TCM_MODE_PRESC: begin
          lo0_d = {lo0_q[7:5], lo0_q[4:0] + 5'h01};
          if (lo0_q[4:0] == `TCM_PRESC_MAX) begin
            hi0_d = hi0_q + 8'h01;
            ovf0 = (hi0_q == `TCM_BYTE_MAX);
          end
        end
        TCM_MODE_WIDE: begin
          {hi0_d, lo0_d} = {hi0_q, lo0_q} + 16'h0001;
          ovf0 = ({hi0_q, lo0_q} == {`TCM_BYTE_MAX, `TCM_BYTE_MAX});
        end
        TCM_MODE_RELOAD: begin
          ovf0 = (lo0_q == `TCM_BYTE_MAX);
          lo0_d = ovf0 ? hi0_q : lo0_q + 8'h01;
        end
        TCM_MODE_SPLIT: begin
          lo0_d = lo0_q + 8'h01;
          ovf0 = (lo0_q == `TCM_BYTE_MAX);
        end
      endcase
    end
    // split high byte is a plain timer under timer 1 run bit, flags timer 1
    if (split0 && inc0_hi_split) begin
      hi0_d = hi0_q + 8'h01;
      ovf1_split = (hi0_q == `TCM_BYTE_MAX);
    end
    if (wr_lo0) begin
      lo0_d = SFR_WDATA;
    end
    if (wr_hi0) begin
      hi0_d = SFR_WDATA;
    end
  end

  // timer 1 next state; split value stops it as in mode 11
  always_comb begin
    lo1_d = lo1_q;
    hi1_d = hi1_q;
    ovf1 = 1'b0;
    if (inc1) begin
      unique case (mode1)
        TCM_MODE_PRESC: begin
          lo1_d = {lo1_q[7:5], lo1_q[4:0] + 5'h01};
          if (lo1_q[4:0] == `TCM_PRESC_MAX) begin
            hi1_d = hi1_q + 8'h01;
            ovf1 = (hi1_q == `TCM_BYTE_MAX);
          end
        end
        TCM_MODE_WIDE: begin
          {hi1_d, lo1_d} = {hi1_q, lo1_q} + 16'h0001;
          ovf1 = ({hi1_q, lo1_q} == {`TCM_BYTE_MAX, `TCM_BYTE_MAX});
        end
        TCM_MODE_RELOAD: begin
          ovf1 = (lo1_q == `TCM_BYTE_MAX);
          lo1_d = ovf1 ? hi1_q : lo1_q + 8'h01;
        end
        TCM_MODE_SPLIT: begin
          ovf1 = 1'b0;
        end
      endcase
    end
    if (wr_lo1) begin
      lo1_d = SFR_WDATA;
    end
    if (wr_hi1) begin
      hi1_d = SFR_WDATA;
    end
  end

  // flags: hardware set wins over both software write and vector clear
  wire set_f0 = ovf0;
  wire set_f1 = ovf1 | ovf1_split;
  wire f0_keep = wr_ctrl ? SFR_WDATA[`TCM_OVF0_BIT] : ctrl_q[`TCM_OVF0_BIT];
  wire f1_keep = wr_ctrl ? SFR_WDATA[`TCM_OVF1_BIT] : ctrl_q[`TCM_OVF1_BIT];
  wire f0_d = set_f0 | (f0_keep & ~(CE & VECTOR_ACK_ZERO));
  wire f1_d = set_f1 | (f1_keep & ~(CE & VECTOR_ACK_ONE));
  wire [7:0] ctrl_base = wr_ctrl ? SFR_WDATA : ctrl_q;
  wire [7:0] ctrl_d = {f1_d, ctrl_base[`TCM_RUN1_BIT], f0_d, ctrl_base[`TCM_RUN0_BIT:0]};

  wire [7:0] rdata_d = (SFR_ADDR == `TCM_ADDR_MODE) ? mode_q :
                       (SFR_ADDR == `TCM_ADDR_CTRL) ? ctrl_q :
                       (SFR_ADDR == `TCM_ADDR_LO0) ? lo0_q :
                       (SFR_ADDR == `TCM_ADDR_HI0) ? hi0_q :
                       (SFR_ADDR == `TCM_ADDR_LO1) ? lo1_q :
                       (SFR_ADDR == `TCM_ADDR_HI1) ? hi1_q : 8'h00;

  always_ff @(posedge REF_CLK or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      mode_q <= `TCM_MODE_RST;
      ctrl_q <= `TCM_CTRL_RST;
      lo0_q <= `TCM_CNT_RST;
      hi0_q <= `TCM_CNT_RST;
      lo1_q <= `TCM_CNT_RST;
      hi1_q <= `TCM_CNT_RST;
      rdata_q <= 8'h00;
    end else if (CE) begin
      if (wr_mode) begin
        mode_q <= SFR_WDATA;
      end
      ctrl_q <= ctrl_d;
      lo0_q <= lo0_d;
      hi0_q <= hi0_d;
      lo1_q <= lo1_d;
      hi1_q <= hi1_d;
      rdata_q <= rdata_d;
    end
  end

  assign SFR_RDATA = rdata_q;
  assign SFR_HIT = hit;
  assign OVERFLOW_FLAG_ZERO = ctrl_q[`TCM_OVF0_BIT];
  assign OVERFLOW_FLAG_ONE = ctrl_q[`TCM_OVF1_BIT];
  assign MODE_ZERO = mode0;
  assign MODE_ONE = mode1;
endmodule
`default_nettype wire

// ==== testbench/tcm_timer01_sva.sv ====
`default_nettype none
module tcm_timer01_sva (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WE,
  input wire logic [7:0] SFR_RDATA,
  input wire logic SFR_HIT,
  input wire logic VECTOR_ACK_ZERO,
  input wire logic VECTOR_ACK_ONE,
  input wire logic OVERFLOW_FLAG_ZERO,
  input wire logic OVERFLOW_FLAG_ONE,
  input wire tcm_pkg::tcm_mode_t MODE_ZERO,
  input wire tcm_pkg::tcm_mode_t MODE_ONE
);
  import tcm_pkg::*;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  wire logic mode_wr = SFR_WE && CE && SFR_ADDR == 8'h89;
  property p_mode; mode_wr |=> MODE_ONE == $past(SFR_WDATA[5:4]) && MODE_ZERO == $past(SFR_WDATA[1:0]); endproperty
  a_mode: assert property (p_mode) else $error("mode fields not loaded");
  property p_mode_hold; !mode_wr |=> $stable(MODE_ONE) && $stable(MODE_ZERO); endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed without write");
  property p_hit; SFR_HIT == (SFR_ADDR >= 8'h88 && SFR_ADDR <= 8'h8d); endproperty
  a_hit: assert property (p_hit) else $error("address decode wrong");
  property p_unmap; CE && !SFR_HIT |=> SFR_RDATA == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_vack; CE && VECTOR_ACK_ZERO |=> !OVERFLOW_FLAG_ZERO; endproperty
  a_vack: assert property (p_vack) else $error("flag zero not cleared by vector");
  property p_hold;
    OVERFLOW_FLAG_ONE && !VECTOR_ACK_ONE && !(SFR_WE && SFR_ADDR == 8'h88) |=> OVERFLOW_FLAG_ONE;
  endproperty
  a_hold: assert property (p_hold) else $error("flag one dropped by itself");
  property p_freeze; !CE |=> $stable(SFR_RDATA) && $stable(OVERFLOW_FLAG_ONE); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");
  // split mode on timer 0 may still raise flag one, and software may write it
  property p_stop;
    MODE_ONE == TCM_MODE_SPLIT && MODE_ZERO != TCM_MODE_SPLIT && !OVERFLOW_FLAG_ONE &&
    !(SFR_WE && SFR_ADDR == 8'h88) |=> !OVERFLOW_FLAG_ONE;
  endproperty
  a_stop: assert property (p_stop) else $error("stopped timer one overflowed");
  c_ovf0: cover property (OVERFLOW_FLAG_ZERO ##1 !OVERFLOW_FLAG_ZERO);
  c_ovf1: cover property ($rose(OVERFLOW_FLAG_ONE));
  c_unmap: cover property (CE && !SFR_HIT);
  c_split: cover property (MODE_ZERO == TCM_MODE_SPLIT && $rose(OVERFLOW_FLAG_ONE));
endmodule
bind tcm_timer01 tcm_timer01_sva i_sva (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE), .SFR_ADDR(SFR_ADDR),
  .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT),
  .VECTOR_ACK_ZERO(VECTOR_ACK_ZERO), .VECTOR_ACK_ONE(VECTOR_ACK_ONE), .OVERFLOW_FLAG_ZERO(OVERFLOW_FLAG_ZERO),
  .OVERFLOW_FLAG_ONE(OVERFLOW_FLAG_ONE), .MODE_ZERO(MODE_ZERO), .MODE_ONE(MODE_ONE));
`default_nettype wire

// ==== testbench/tcm_pins.sv ====
`default_nettype none
// event source: idles high like a pulled-up pin, sends num falls
module tcm_pins (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] num,
  output logic ev
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] left_q = 9'h000;
  initial ev = 1'b1;
  // each level held exactly one cycle: the fastest legal source
  always @(posedge clk) begin
    if (go) begin
      left_q <= {num, 1'b0};
    end else if (left_q != 9'h000) begin
      left_q <= left_q - 9'h001;
      ev <= ~ev;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`default_nettype none
module testbench;
  import tcm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, ce, we, go, ev, g0, g1, ack0, ack1, hit, f0, f1;
  logic [7:0] addr, wdata, rdata, num;
  tcm_mode_t m0, m1;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  tcm_timer01 i_dut (.REF_CLK(clk), .RST_N(rst_n), .CE(ce), .SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_WE(we),
    .SFR_RDATA(rdata), .SFR_HIT(hit), .EVENT_PIN_ZERO(ev), .EVENT_PIN_ONE(ev), .GATE_PIN_ZERO(g0),
    .GATE_PIN_ONE(g1), .VECTOR_ACK_ZERO(ack0), .VECTOR_ACK_ONE(ack1), .OVERFLOW_FLAG_ZERO(f0),
    .OVERFLOW_FLAG_ONE(f1), .MODE_ZERO(m0), .MODE_ONE(m1));
  tcm_pins i_pins (.clk(clk), .go(go), .num(num), .ev(ev));
  always #50 clk = ~clk;
  task automatic stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin
      addr <= a;
      wdata <= d;
      we <= 1'b1;
    end
    @(posedge clk) we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
    @(posedge clk) addr <= a;
    @(posedge clk) #1 chk(rdata & m, exp);
  endtask
  // timer must be stopped first, else a fresh overflow wins over the clear
  task automatic vec(input logic one);
    @(posedge clk) {ack1, ack0} <= one ? 2'b10 : 2'b01;
    @(posedge clk) {ack1, ack0} <= 2'b00;
    #1 chk({6'h0, f1, f0}, 8'h00);
  endtask
  task automatic flags(input int n, input logic [1:0] exp);
    repeat (n) @(posedge clk);
    #1 chk({6'h0, f1, f0}, {6'h0, exp});
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    we = 1'b0;
    go = 1'b0;
    num = 8'h05;
    g0 = 1'b0;
    g1 = 1'b0;
    ack0 = 1'b0;
    ack1 = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 8'h88; a <= 8'h8e; a++) begin
      rd(8'(a), 8'h00);
    end
    wr(8'h89, 8'ha5);
    rd(8'h89, 8'ha5);
    chk({4'h0, m1, m0}, 8'h09);
    $display("register test done");
    wr(8'h89, 8'h01);
    wr(8'h8a, 8'hfe);
    wr(8'h8c, 8'hff);
    wr(8'h88, 8'h10);
    flags(4, 2'b01);
    wr(8'h88, 8'h20);
    rd(8'h8c, 8'h00);
    vec(1'b0);
    wr(8'h89, 8'h00);
    wr(8'h8b, 8'hfe);
    wr(8'h8d, 8'hff);
    wr(8'h88, 8'h40);
    flags(4, 2'b10);
    wr(8'h88, 8'h80);
    rd(8'h8d, 8'h00);
    rd(8'h8b, 8'he0, 8'he0);
    vec(1'b1);
    wr(8'h89, 8'h02);
    wr(8'h8c, 8'hf0);
    wr(8'h8a, 8'hfe);
    wr(8'h88, 8'h10);
    flags(4, 2'b01);
    wr(8'h88, 8'h20);
    rd(8'h8c, 8'hf0);
    rd(8'h8a, 8'hf0, 8'hf0);
    vec(1'b0);
    $display("mode test done");
    wr(8'h89, 8'h30);
    wr(8'h8b, 8'h55);
    wr(8'h88, 8'h40);
    @(posedge clk) ce <= 1'b0;
    @(posedge clk) ce <= 1'b1;
    flags(6, 2'b00);
    rd(8'h8b, 8'h55);
    $display("stop test done");
    wr(8'h89, 8'h99);
    wr(8'h8a, 8'hfe);
    wr(8'h8c, 8'hff);
    wr(8'h8b, 8'hfe);
    wr(8'h8d, 8'hff);
    wr(8'h88, 8'h50);
    flags(6, 2'b00);
    @(posedge clk) begin
      g0 <= 1'b1;
      g1 <= 1'b1;
    end
    flags(6, 2'b11);
    wr(8'h88, 8'h00);
    $display("gate test done");
    wr(8'h89, 8'h55);
    for (int a = 8'h8a; a <= 8'h8d; a++) begin
      wr(8'(a), 8'h00);
    end
    wr(8'h88, 8'h50);
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    repeat (14) @(posedge clk);
    rd(8'h8a, 8'h05);
    rd(8'h8b, 8'h05);
    $display("counter test done");
    // split: both bytes of timer 0 wrap together, then only the high byte follows run bit one
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h03);
    wr(8'h8a, 8'hfe);
    wr(8'h8c, 8'hfe);
    wr(8'h88, 8'h50);
    flags(4, 2'b11);
    wr(8'h88, 8'ha0);
    rd(8'h8a, 8'h04);
    rd(8'h8c, 8'h04);
    wr(8'h88, 8'h40);
    flags(2, 2'b00);
    wr(8'h88, 8'h00);
    rd(8'h8a, 8'h04);
    rd(8'h8c, 8'h08);
    $display("split test done");
    stop_test();
  end
endmodule
`default_nettype wire
